/* File: hdl/fpu_misc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module fpu_misc_top (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	// AHB-Lite slave
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic [31:0]      O_HRDATA,
	output logic             O_HREADYOUT,
	output logic             O_HRESP
);
	typedef logic [81:0] fr_t;

	fpu_status_if st ();

	////////////////////////////////////////////////////////////////////
	// Bus address phase capture
	logic       wr_q, rd_q;
	logic [7:0] addr_q;
	wire  take = I_HSEL && I_HREADY && I_HTRANS[1];

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_q   <= take && I_HWRITE;
			rd_q   <= take && !I_HWRITE;
			addr_q <= take ? I_HADDR[7:0] : addr_q;
		end
	end
	assign O_HREADYOUT = 1'b1; // Zero wait states
	assign O_HRESP     = 1'b0;

	// Decode used for both write strobes and read mux
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	////////////////////////////////////////////////////////////////////
	// Operand registers and command
	fr_t        opa_q, opb_q;
	logic [31:0] cmd_q;
	logic       go_q;

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			opa_q <= '0;
			opb_q <= '0;
		end else if (wr_q) begin
			if (hit(addr_q, fpu_misc_pkg::OFF_OPA_LO)) opa_q[31:0]  <= I_HWDATA;
			if (hit(addr_q, fpu_misc_pkg::OFF_OPA_HI)) opa_q[63:32] <= I_HWDATA;
			if (hit(addr_q, fpu_misc_pkg::OFF_OPA_SE)) opa_q[81:64] <= I_HWDATA[17:0];
			if (hit(addr_q, fpu_misc_pkg::OFF_OPB_LO)) opb_q[31:0]  <= I_HWDATA;
			if (hit(addr_q, fpu_misc_pkg::OFF_OPB_HI)) opb_q[63:32] <= I_HWDATA;
			if (hit(addr_q, fpu_misc_pkg::OFF_OPB_SE)) opb_q[81:64] <= I_HWDATA[17:0];
		end
	end

	// Command: [3:0] op, [5:4] field, [7:6] static pc, [9:8] memtype,
	// [18:10] class mask
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cmd_q <= 32'h0000_0000;
			go_q  <= 1'b0;
		end else begin
			go_q  <= wr_q && hit(addr_q, fpu_misc_pkg::OFF_CMD);
			cmd_q <= (wr_q && hit(addr_q, fpu_misc_pkg::OFF_CMD))
				? I_HWDATA : cmd_q;
		end
	end

	fpu_misc_pkg::op_t op;
	logic [1:0] sfsel, pstat, mtype;
	logic [8:0] cmask;
	assign op    = fpu_misc_pkg::op_t'(cmd_q[3:0]);
	assign sfsel = cmd_q[5:4];
	assign pstat = cmd_q[7:6];
	assign mtype = cmd_q[9:8];
	assign cmask = cmd_q[18:10];

	////////////////////////////////////////////////////////////////////
	// Operand classification
	function automatic logic is_nan(input fr_t v);
		is_nan = (v[80:64] == fpu_misc_pkg::EXP_MAX) && (v[62:0] != 63'h0);
	endfunction : is_nan
	function automatic logic is_inf(input fr_t v);
		is_inf = (v[80:64] == fpu_misc_pkg::EXP_MAX) && (v[62:0] == 63'h0);
	endfunction : is_inf
	function automatic logic is_zero(input fr_t v);
		is_zero = (v[63:0] == 64'h0);
	endfunction : is_zero
	// Signed less-than, magnitude-only when abs; false when either is NaN
	function automatic logic lt(input fr_t a, input fr_t b, input logic abs);
		logic sa, sb, ml;
		sa = abs ? 1'b0 : a[81];
		sb = abs ? 1'b0 : b[81];
		ml = a[80:0] < b[80:0];
		if (is_nan(a) || is_nan(b)) lt = 1'b0;
		else if (is_zero(a) && is_zero(b)) lt = 1'b0;
		else if (sa != sb) lt = sa;
		else lt = sa ? (b[80:0] < a[80:0]) : ml;
	endfunction : lt

	// Class bits: 0 +, 1 -, 2 zero, 3 unnorm, 4 norm, 5 inf,
	// 6 snan, 7 qnan, 8 nat (never set, held at 0)
	logic [8:0] cls;
	always_comb begin
		cls    = 9'h000;
		cls[0] = !opa_q[81];
		cls[1] = opa_q[81];
		cls[2] = is_zero(opa_q) && !is_nan(opa_q);
		cls[3] = !opa_q[63] && !is_zero(opa_q);
		cls[4] = opa_q[63] && opa_q[80:64] != fpu_misc_pkg::EXP_MAX;
		cls[5] = is_inf(opa_q);
		cls[6] = is_nan(opa_q) && !opa_q[62];
		cls[7] = is_nan(opa_q) && opa_q[62];
	end
	wire cls_hit = |(cmask[8:5] & cls[8:5]) |
		(|(cmask[1:0] & cls[1:0]) && |(cmask[4:2] & cls[4:2]));

	////////////////////////////////////////////////////////////////////
	// Reciprocal estimate: 8-bit table-free seed from leading significand
	logic [7:0] rcp_m;
	logic       rcp_special, rcp_assist;
	assign rcp_m = 8'(16'hFF00 / {8'h01, opb_q[62:55]});
	assign rcp_special = is_zero(opb_q) || is_inf(opb_q) || is_nan(opb_q)
		|| is_nan(opa_q) || is_inf(opa_q) || is_zero(opa_q);
	assign rcp_assist = !rcp_special && (opb_q[80:64] < 17'h0100
		|| opb_q[80:64] > 17'h1FE00);

	// Significand trimmed to static or field precision
	function automatic logic [63:0] round_sig(input logic [63:0] s,
		input logic [1:0] ps, input logic [12:0] ctl);
		logic [1:0] pc;
		pc = (ps != fpu_misc_pkg::PS_DYN) ? ps
			: ctl[fpu_misc_pkg::PC_LSB +: 2];
		unique case (pc)
			2'h1: round_sig = {s[63:40], 40'h0};
			2'h2: round_sig = {s[63:11], 11'h0};
			default: round_sig = s;
		endcase
	endfunction : round_sig

	////////////////////////////////////////////////////////////////////
	// Datapath result
	fr_t        res_d;
	logic [5:0] flg_d;
	logic       pred_d, fault_d;
	logic [63:0] mag;
	logic [6:0]  lz;

	always_comb begin
		res_d   = '0;
		flg_d   = 6'h00;
		pred_d  = 1'b0;
		fault_d = 1'b0;
		mag     = opa_q[63] ? 64'(-opa_q[63:0]) : opa_q[63:0];
		lz      = 7'd0;
		for (int k = 0; k < 64; k++) if (mag[k]) lz = 7'(63 - k);
		unique case (op)
			fpu_misc_pkg::OP_RCPA: begin
				if (rcp_special) begin
					res_d[81] = opa_q[81] ^ opb_q[81];
					if (is_nan(opa_q) || is_nan(opb_q) ||
						(is_zero(opa_q) && is_zero(opb_q)) ||
						(is_inf(opa_q) && is_inf(opb_q))) begin
						res_d = {1'b0, fpu_misc_pkg::EXP_MAX, 2'b11, 62'h0};
						flg_d[fpu_misc_pkg::FLG_V] = 1'b1;
					end else if (is_zero(opb_q) || is_inf(opa_q)) begin
						res_d[80:0] = {fpu_misc_pkg::EXP_MAX, 1'b1, 63'h0};
						flg_d[fpu_misc_pkg::FLG_Z] = is_zero(opb_q);
					end
				end else if (rcp_assist) begin
					fault_d = 1'b1;
				end else begin
					res_d = {opb_q[81],
						17'(2 * fpu_misc_pkg::EXP_BIAS - opb_q[80:64] - 17'h1),
						rcp_m, 56'h0};
					pred_d = 1'b1;
					flg_d[fpu_misc_pkg::FLG_D] = !opb_q[63];
				end
			end
			fpu_misc_pkg::OP_CLASS:  pred_d = cls_hit;
			fpu_misc_pkg::OP_MIN:
				res_d = lt(opa_q, opb_q, 1'b0) ? opa_q : opb_q;
			fpu_misc_pkg::OP_MAX:
				res_d = lt(opa_q, opb_q, 1'b0) ? opb_q : opa_q;
			fpu_misc_pkg::OP_AMIN:
				res_d = lt(opa_q, opb_q, 1'b1) ? opa_q : opb_q;
			fpu_misc_pkg::OP_AMAX:
				res_d = lt(opa_q, opb_q, 1'b1) ? opb_q : opa_q;
			fpu_misc_pkg::OP_SETSIG:
				res_d = {1'b0, 17'h1003E, opa_q[63:0]};
			fpu_misc_pkg::OP_I2F: begin
				res_d[81] = opa_q[63];
				res_d[80:64] = is_zero(opa_q) ? 17'h0
					: 17'(17'h1003E - 17'(lz));
				res_d[63:0] = round_sig(64'(mag << lz), pstat, st.ctl);
			end
			fpu_misc_pkg::OP_F2I, fpu_misc_pkg::OP_F2U: begin
				res_d[63:0] = (opa_q[80:64] > 17'h1003E) ? 64'h0
					: 64'(opa_q[63:0] >> 7'(17'h1003E - opa_q[80:64]));
				if (op == fpu_misc_pkg::OP_F2I && opa_q[81])
					res_d[63:0] = 64'(-res_d[63:0]);
				flg_d[fpu_misc_pkg::FLG_V] = is_nan(opa_q) || is_inf(opa_q);
			end
			fpu_misc_pkg::OP_GETEXP:
				res_d[17:0] = opa_q[81:64];
			fpu_misc_pkg::OP_SETEXP:
				res_d = {opa_q[17:0], 1'b1, 63'h0};
			fpu_misc_pkg::OP_MERGE:
				res_d = {opa_q[81:64], opb_q[63:0]};
			fpu_misc_pkg::OP_LOAD: begin
				unique case (mtype)
					fpu_misc_pkg::MT_SGL: res_d = {opa_q[31],
						(opa_q[30:23] == 8'h00) ? 17'h0 :
						17'(17'(opa_q[30:23]) + 17'h0FF80),
						opa_q[30:23] != 8'h00, opa_q[22:0], 40'h0};
					fpu_misc_pkg::MT_DBL: res_d = {opa_q[63],
						(opa_q[62:52] == 11'h000) ? 17'h0 :
						17'(17'(opa_q[62:52]) + 17'h0FC00),
						opa_q[62:52] != 11'h000, opa_q[51:0], 11'h0};
					default: res_d = {opa_q[79], 2'b00, opa_q[78:64],
						opa_q[63:0]};
				endcase
			end
			default: res_d = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Result registers and status feed
	fr_t  res_q;
	logic pred_q, fault_q;

	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			res_q   <= '0;
			pred_q  <= 1'b0;
			fault_q <= 1'b0;
		end else if (go_q) begin
			res_q   <= fault_d ? res_q : res_d;
			pred_q  <= pred_d && !fault_d;
			fault_q <= fault_d;
		end
	end

	assign st.upd   = go_q && !fault_d;
	assign st.sel   = sfsel;
	assign st.flags = flg_d;

	logic [51:0] ctl_all;
	logic [23:0] flg_all;
	fpu_status_store u_store (
		.i_clk        (I_CLK),
		.i_reset_n    (I_RESET_N),
		.st           (st.store),
		.i_ctl_we     (wr_q && addr_q[7:4] == 4'h0),
		.i_ctl_idx    (addr_q[3:2]),
		.i_ctl_wdata  (I_HWDATA[12:0]),
		.i_flg_we     (wr_q && addr_q[7:4] == 4'h1),
		.i_flg_idx    (addr_q[3:2]),
		.i_flg_wdata  (I_HWDATA[5:0]),
		.i_commit     (wr_q && hit(addr_q, fpu_misc_pkg::OFF_COMMIT)),
		.i_commit_idx (I_HWDATA[1:0]),
		.o_ctl_all    (ctl_all),
		.o_flg_all    (flg_all)
	);

	////////////////////////////////////////////////////////////////////
	// Read data, registered-address mux
	always_comb begin
		O_HRDATA = 32'h0000_0000;
		if (rd_q) begin
			if (addr_q[7:4] == 4'h0)
				O_HRDATA = {19'h0, ctl_all[addr_q[3:2]*13 +: 13]};
			else if (addr_q[7:4] == 4'h1)
				O_HRDATA = {26'h0, flg_all[addr_q[3:2]*6 +: 6]};
			else if (hit(addr_q, fpu_misc_pkg::OFF_STATE))
				O_HRDATA = {30'h0, fault_q, pred_q};
			else if (hit(addr_q, fpu_misc_pkg::OFF_CMD))
				O_HRDATA = cmd_q;
			else if (hit(addr_q, fpu_misc_pkg::OFF_RES_LO))
				O_HRDATA = res_q[31:0];
			else if (hit(addr_q, fpu_misc_pkg::OFF_RES_HI))
				O_HRDATA = res_q[63:32];
			else if (hit(addr_q, fpu_misc_pkg::OFF_RES_SE))
				O_HRDATA = {14'h0, res_q[81:64]};
		end
	end

	a_fault_clears : assert property (@(posedge I_CLK)
		disable iff (!I_RESET_N) (go_q && fault_d) |=> !pred_q)
		else $error("assist fault left predicate set");
	a_min_order : assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		(go_q && op == fpu_misc_pkg::OP_MIN && !lt(opa_q, opb_q, 1'b0))
		|=> res_q == $past(opb_q))
		else $error("min did not return second operand");
	a_max_order : assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		(go_q && op == fpu_misc_pkg::OP_MAX && lt(opa_q, opb_q, 1'b0))
		|=> res_q == $past(opb_q))
		else $error("max did not return second operand");
	a_nan_fallback : assert property (@(posedge I_CLK)
		disable iff (!I_RESET_N) (go_q && op == fpu_misc_pkg::OP_AMIN
		&& is_nan(opa_q)) |=> res_q == $past(opb_q))
		else $error("NaN comparison not false");
	a_merge_form : assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		(go_q && op == fpu_misc_pkg::OP_MERGE) |=> res_q[63:0]
		== $past(opb_q[63:0]) && res_q[81:64] == $past(opa_q[81:64]))
		else $error("merge fields wrong");
	a_class_pair : assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		(go_q && op == fpu_misc_pkg::OP_CLASS) |=> pred_q == $past(cls_hit))
		else $error("class predicate wrong");
	a_special_pred : assert property (@(posedge I_CLK)
		disable iff (!I_RESET_N) (go_q && op == fpu_misc_pkg::OP_RCPA
		&& rcp_special) |=> !pred_q && !fault_q)
		else $error("special divide set predicate");
	a_sig_copy : assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
		(go_q && op == fpu_misc_pkg::OP_SETSIG)
		|=> res_q[63:0] == $past(opa_q[63:0]))
		else $error("significand not copied unchanged");
endmodule : fpu_misc_top
`default_nettype wire

/* File: hdl/fpu_misc_pkg.sv */
package fpu_misc_pkg;
	// Register-format value: sign, 17-bit exponent, 64-bit significand
	localparam int EXP_W  = 17;
	localparam int SIG_W  = 64;
	localparam int FR_W   = 82;
	localparam int SIGN_POS = 81;
	localparam logic [16:0] EXP_BIAS = 17'h0FFFF;
	localparam logic [16:0] EXP_MAX  = 17'h1FFFF;
	// Status field: 13 bits, traps[5:0] ctl[12:6] flags in separate word
	localparam int FLD_W  = 13;
	localparam int FLG_W  = 6;
	localparam int FLG_V  = 0;
	localparam int FLG_D  = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_O  = 3;
	localparam int FLG_U  = 4;
	localparam int FLG_I  = 5;
	localparam int RC_LSB = 8;
	localparam int PC_LSB = 10;
	localparam int WRE_POS = 12;
	localparam logic [12:0] FLD_RESET = 13'h033F;
	// Field selector codes
	localparam logic [1:0] SF_ARCH = 2'h0;
	localparam logic [1:0] SF_SCR  = 2'h1;
	localparam logic [1:0] SF_SPA  = 2'h2;
	localparam logic [1:0] SF_SPB  = 2'h3;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL0  = 8'h00;
	localparam logic [7:0] OFF_FLAGS0 = 8'h10;
	localparam logic [7:0] OFF_COMMIT = 8'h20;
	localparam logic [7:0] OFF_STATE  = 8'h24;
	localparam logic [7:0] OFF_OPA_LO = 8'h40;
	localparam logic [7:0] OFF_OPA_HI = 8'h44;
	localparam logic [7:0] OFF_OPA_SE = 8'h48;
	localparam logic [7:0] OFF_OPB_LO = 8'h50;
	localparam logic [7:0] OFF_OPB_HI = 8'h54;
	localparam logic [7:0] OFF_OPB_SE = 8'h58;
	localparam logic [7:0] OFF_CMD    = 8'h60;
	localparam logic [7:0] OFF_RES_LO = 8'h70;
	localparam logic [7:0] OFF_RES_HI = 8'h74;
	localparam logic [7:0] OFF_RES_SE = 8'h78;
	// Reciprocal estimate precision
	localparam int RCP_BITS = 8;
	// Operation codes
	typedef enum logic [3:0] {
		OP_RCPA   = 4'h0,
		OP_CLASS  = 4'h1,
		OP_MIN    = 4'h2,
		OP_MAX    = 4'h3,
		OP_AMIN   = 4'h4,
		OP_AMAX   = 4'h5,
		OP_SETSIG = 4'h6,
		OP_I2F    = 4'h7,
		OP_F2I    = 4'h8,
		OP_F2U    = 4'h9,
		OP_GETEXP = 4'hA,
		OP_SETEXP = 4'hB,
		OP_MERGE  = 4'hC,
		OP_LOAD   = 4'hD
	} op_t;
	// Memory format on loads
	localparam logic [1:0] MT_SGL = 2'h0;
	localparam logic [1:0] MT_DBL = 2'h1;
	localparam logic [1:0] MT_EXT = 2'h2;
	// Static precision in command
	localparam logic [1:0] PS_DYN = 2'h0;
	localparam logic [1:0] PS_SGL = 2'h1;
	localparam logic [1:0] PS_DBL = 2'h2;
endpackage : fpu_misc_pkg

/* File: hdl/fpu_status_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Status-field update carrier between datapath and field store
interface fpu_status_if;
	logic       upd;
	logic [1:0] sel;
	logic [5:0] flags;
	logic [12:0] ctl;
	modport core  (output upd, output sel, output flags, input ctl);
	modport store (input upd, input sel, input flags, output ctl);
endinterface : fpu_status_if
`default_nettype wire

/* File: hdl/fpu_status_store.sv */
`timescale 1ns/100ps
`default_nettype none
module fpu_status_store (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	fpu_status_if.store      st,
	// Software access
	input  wire logic        i_ctl_we,
	input  wire logic [1:0]  i_ctl_idx,
	input  wire logic [12:0] i_ctl_wdata,
	input  wire logic        i_flg_we,
	input  wire logic [1:0]  i_flg_idx,
	input  wire logic [5:0]  i_flg_wdata,
	input  wire logic        i_commit,
	input  wire logic [1:0]  i_commit_idx,
	output logic [51:0]      o_ctl_all,
	output logic [23:0]      o_flg_all
);
	logic [12:0] ctl_q [4];
	logic [5:0]  flg_q [4];

	////////////////////////////////////////////////////////////////////
	// Four fields, alike except for the commit path into index 0; index 0 is architectural
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : gen_fld
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					ctl_q[g] <= fpu_misc_pkg::FLD_RESET;
				end else if (i_ctl_we && i_ctl_idx == 2'(g)) begin
					ctl_q[g] <= i_ctl_wdata;
				end
			end
			// Hardware set wins over software clear; commit ORs into field 0
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					flg_q[g] <= 6'h00;
				end else begin
					flg_q[g] <= ((i_flg_we && i_flg_idx == 2'(g))
						? i_flg_wdata : flg_q[g])
						| ((st.upd && st.sel == 2'(g)) ? st.flags : 6'h00)
						| ((g == 0 && i_commit && i_commit_idx != 2'h0)
						? flg_q[i_commit_idx] : 6'h00);
				end
			end
		end
	endgenerate

	// Flatten fields for the read mux; one process keeps one driver
	always_comb begin
		for (int n = 0; n < 4; n++) begin
			o_ctl_all[n*13 +: 13] = ctl_q[n];
			o_flg_all[n*6 +: 6]   = flg_q[n];
		end
	end

	assign st.ctl = ctl_q[st.sel];

	a_fld_isolate : assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st.upd && st.sel != 2'h0 && !i_flg_we && !i_commit)
		|=> flg_q[0] == $past(flg_q[0]))
		else $error("extra field update leaked into architectural flags");
	a_fld_sticky : assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(st.upd && st.flags != 6'h00)
		|=> (flg_q[$past(st.sel)] & $past(st.flags)) == $past(st.flags))
		else $error("flags not recorded in selected field");
endmodule : fpu_status_store
`default_nettype wire

/* File: verification/fpu_misc_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module fpu_misc_top_bench;
	// Register-format constants: sign, exponent, significand
	localparam logic [81:0] ONE = {1'b0, 17'h0FFFF, 64'h8000000000000000};
	localparam logic [81:0] TWO = {1'b0, 17'h10000, 64'h8000000000000000};
	localparam logic [81:0] TH  = {1'b0, 17'h10000, 64'hC000000000000000};
	localparam logic [81:0] M3  = {1'b1, 17'h10000, 64'hC000000000000000};
	localparam logic [81:0] M2  = {1'b1, 17'h10000, 64'h8000000000000000};
	localparam logic [81:0] H15 = {1'b0, 17'h0FFFF, 64'hC000000000000000};
	localparam logic [81:0] QN  = {1'b0, 17'h1FFFF, 64'hC000000000000000};
	localparam logic [81:0] INF = {1'b0, 17'h1FFFF, 64'h8000000000000000};
	localparam logic [81:0] TINY = {1'b0, 17'h00050, 64'h8000000000000000};
	localparam logic [81:0] ALL = 82'h3FFFFFFFFFFFFFFFFFFFF;
	localparam logic [81:0] L64 = 82'h0FFFFFFFFFFFFFFFF;
	localparam logic [81:0] NO  = 82'h0;
	typedef struct {
		logic [81:0] a, b, r, m;
		logic [31:0] cmd;
		logic [1:0]  st;
		logic        cs;
	} row_t;
	logic        I_CLK, I_RESET_N, hsel, hwrite;
	logic [31:0] haddr, hwdata, O_HRDATA, rdata_q;
	logic [1:0]  htrans;
	logic        O_HREADYOUT, O_HRESP, hrdy_q;
	wire logic   hready;
	int          n_mismatch, compares, k;
	row_t        rows[$];
	// One slave, so its ready is the bus ready
	assign hready = O_HREADYOUT;
	fpu_misc_top i_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_HSEL(hsel),
		.I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HRDATA(O_HRDATA), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP));
	////////////////////////////////////////////////////////////////////////////
	// Capture what stood at each edge, free of scheduling races
	always @(posedge I_CLK) begin
		hrdy_q <= O_HREADYOUT;
		rdata_q <= O_HRDATA;
	end
	// Clock, 5 ns period
	initial begin
		I_CLK = 1'b0;
		forever #2.5 I_CLK = ~I_CLK;
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic check(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Single transfer; waits on ready, no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] rd);
		@(posedge I_CLK);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge I_CLK);
		#1;
		while (hrdy_q !== 1'b1) begin
			@(posedge I_CLK);
			#1;
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge I_CLK);
		#1;
		while (hrdy_q !== 1'b1) begin
			@(posedge I_CLK);
			#1;
		end
		rd = rdata_q;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask : wr
	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(nm, v & m, e & m);
	endtask : rdc
	// An 82-bit operand always goes as three words
	task automatic opnd(input logic [7:0] base, input logic [81:0] v);
		wr(base, v[31:0]);
		wr(base + 8'h04, v[63:32]);
		wr(base + 8'h08, {14'h0, v[81:64]});
	endtask : opnd
	task automatic run(input logic [81:0] a, b, input logic [31:0] c);
		opnd(8'h40, a);
		opnd(8'h50, b);
		wr(8'h60, c);
	endtask : run
	function automatic logic [31:0] mk(input logic [3:0] op,
		input logic [1:0] sf, ps, mt, input logic [8:0] cm);
		return {13'h0, cm, mt, ps, sf, op};
	endfunction : mk
	task automatic add(input logic [81:0] a, b, input logic [31:0] c,
		input logic [81:0] r, m, input logic [1:0] st, input logic cs);
		rows.push_back('{a, b, r, m, c, st, cs});
	endtask : add
	////////////////////////////////////////////////////////////////////////////
	// Watchdog, well beyond the roughly one thousand cycles needed
	initial begin
		#100000;
		n_mismatch++;
		results();
	end
	// Main sequence
	initial begin
		I_RESET_N = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		add(ONE, TWO, mk(4'h2, 2'h0, 2'h0, 2'h0, 9'h0), ONE, ALL, 2'h0, 1'b0);
		add(TWO, ONE, mk(4'h2, 2'h1, 2'h0, 2'h0, 9'h0), ONE, ALL, 2'h0, 1'b0);
		add(ONE, TWO, mk(4'h3, 2'h2, 2'h0, 2'h0, 9'h0), TWO, ALL, 2'h0, 1'b0);
		add(TWO, ONE, mk(4'h3, 2'h3, 2'h0, 2'h0, 9'h0), TWO, ALL, 2'h0, 1'b0);
		add(QN, ONE, mk(4'h2, 2'h0, 2'h0, 2'h0, 9'h0), ONE, ALL, 2'h0, 1'b0);
		add(ONE, QN, mk(4'h2, 2'h0, 2'h0, 2'h0, 9'h0), QN, ALL, 2'h0, 1'b0);
		add(QN, ONE, mk(4'h3, 2'h0, 2'h0, 2'h0, 9'h0), QN, ALL, 2'h0, 1'b0);
		add(QN, ONE, mk(4'h4, 2'h0, 2'h0, 2'h0, 9'h0), ONE, ALL, 2'h0, 1'b0);
		add(M3, TWO, mk(4'h4, 2'h0, 2'h0, 2'h0, 9'h0), TWO, ALL, 2'h0, 1'b0);
		add(TWO, M3, mk(4'h4, 2'h0, 2'h0, 2'h0, 9'h0), TWO, ALL, 2'h0, 1'b0);
		add(M3, TWO, mk(4'h5, 2'h0, 2'h0, 2'h0, 9'h0), M3, ALL, 2'h0, 1'b0);
		add(82'h5, NO, mk(4'h6, 2'h0, 2'h0, 2'h0, 9'h0), 82'h5, L64, 2'h0, 1'b0);
		add(82'h3, NO, mk(4'h7, 2'h0, 2'h0, 2'h0, 9'h0), TH, ALL, 2'h0, 1'b0);
		add(L64 - 82'h2, NO, mk(4'h7, 2'h0, 2'h0, 2'h0, 9'h0), M3, ALL, 2'h0,
			1'b0);
		add(82'h1FFFFFF, NO, mk(4'h7, 2'h0, 2'h1, 2'h0, 9'h0),
			{1'b0, 17'h10017, 64'hFFFFFF0000000000}, ALL, 2'h0, 1'b0);
		add(M3, NO, mk(4'h8, 2'h0, 2'h0, 2'h0, 9'h0), L64 - 82'h2, L64, 2'h0,
			1'b0);
		add(TH, NO, mk(4'h9, 2'h0, 2'h0, 2'h0, 9'h0), 82'h3, L64, 2'h0, 1'b0);
		add(M2, NO, mk(4'hA, 2'h0, 2'h0, 2'h0, 9'h0), 82'h30000, 82'h3FFFF,
			2'h0, 1'b0);
		add(82'h2FFFF, NO, mk(4'hB, 2'h0, 2'h0, 2'h0, 9'h0), {18'h2FFFF, 64'h0},
			ALL - L64, 2'h0, 1'b0);
		add(M2, H15, mk(4'hC, 2'h0, 2'h0, 2'h0, 9'h0), M3, ALL, 2'h0, 1'b0);
		add(82'h3F800000, NO, mk(4'hD, 2'h0, 2'h0, 2'h0, 9'h0), ONE, ALL, 2'h0,
			1'b0);
		add(82'h3FF0000000000000, NO, mk(4'hD, 2'h0, 2'h0, 2'h1, 9'h0), ONE, ALL,
			2'h0, 1'b0);
		add(QN, NO, mk(4'h1, 2'h0, 2'h0, 2'h0, 9'h080), NO, NO, 2'h1, 1'b1);
		add(ONE, NO, mk(4'h1, 2'h0, 2'h0, 2'h0, 9'h020), NO, NO, 2'h0, 1'b1);
		add(ONE, NO, mk(4'h1, 2'h0, 2'h0, 2'h0, 9'h011), NO, NO, 2'h1, 1'b1);
		add(ONE, TWO, mk(4'h0, 2'h1, 2'h0, 2'h0, 9'h0), 82'hFF00000000000000,
			82'hFF00000000000000, 2'h1, 1'b1);
		add(ONE, TINY, mk(4'h0, 2'h1, 2'h0, 2'h0, 9'h0), NO, NO, 2'h2, 1'b1);
		repeat (5) @(posedge I_CLK);
		I_RESET_N <= 1'b1;
		#1;
		check("hreadyout", {31'h0, O_HREADYOUT}, 32'h1);
		check("hresp", {31'h0, O_HRESP}, 32'h0);
		// Reset values of all four fields
		for (k = 0; k < 4; k++) begin
			rdc("ctl", {k[5:0], 2'h0}, 32'h033F);
			rdc("flags", 8'h10 + {k[5:0], 2'h0}, 32'h0);
		end
		// Table of operations
		foreach (rows[i]) begin
			run(rows[i].a, rows[i].b, rows[i].cmd);
			rdc("res_lo", 8'h70, rows[i].r[31:0], rows[i].m[31:0]);
			rdc("res_hi", 8'h74, rows[i].r[63:32], rows[i].m[63:32]);
			rdc("res_se", 8'h78, {14'h0, rows[i].r[81:64]},
				{14'h0, rows[i].m[81:64]});
			if (rows[i].cs)
				rdc("state", 8'h24, {30'h0, rows[i].st});
		end
		// Per-field control and flag storage stay apart
		wr(8'h04, 32'h1F3F);
		rdc("ctl1", 8'h04, 32'h1F3F);
		rdc("ctl0", 8'h00, 32'h033F);
		wr(8'h1C, 32'h15);
		rdc("flags3", 8'h1C, 32'h15);
		// Finite over zero in a speculative field
		run(ONE, NO, mk(4'h0, 2'h2, 2'h0, 2'h0, 9'h0));
		rdc("state", 8'h24, 32'h0);
		rdc("res_se", 8'h78, {14'h0, INF[81:64]});
		rdc("res_hi", 8'h74, INF[63:32]);
		rdc("flags2", 8'h18, 32'h04);
		rdc("flags0", 8'h10, 32'h0);
		rdc("flags1", 8'h14, 32'h0);
		rdc("flags3", 8'h1C, 32'h15);
		// Commit ORs the speculative flags into the main field
		wr(8'h20, 32'h2);
		rdc("flags0", 8'h10, 32'h04);
		// Unmapped place: write ignored, reads zero
		wr(8'h30, 32'hFFFFFFFF);
		rdc("unmapped", 8'h30, 32'h0);
		// Second reset in mid-run clears flags and restores controls to 033F
		@(posedge I_CLK);
		I_RESET_N <= 1'b0;
		repeat (2) @(posedge I_CLK);
		I_RESET_N <= 1'b1;
		rdc("flags0", 8'h10, 32'h0);
		rdc("ctl1", 8'h04, 32'h033F);
		results();
	end
endmodule : fpu_misc_top_bench
`default_nettype wire
